// *** logic/adcb_regs.vh ***
`ifndef ADCB_REGS_VH
`define ADCB_REGS_VH

// Register indices (byte address = index)
`define ADCB_ADDR_W          4
`define ADCB_IDX_BUFLEN      4'h0
`define ADCB_IDX_PINHI       4'h1
`define ADCB_IDX_STATUS      4'h2

`define ADCB_DATA_W          16
`define ADCB_BUFLEN_W        3
`define ADCB_BUFLEN_LSB      0
`define ADCB_BUFLEN_MSB      2
`define ADCB_BUFLEN_RST      3'h0
`define ADCB_PINHI_RST       16'h0000
`define ADCB_PIN_BASE        16
`define ADCB_WORDS_W         8
`define ADCB_ZERO16          16'h0000
`define ADCB_BUFLEN_PAD      13'h0000
`define ADCB_STATUS_PAD      15'h0000
`define ADCB_WORDS_ONE       8'h01

`endif

// *** logic/adcb_words_dec.v ***
`timescale 1ns/1ps
// Buffer-length code to words per input
module adcb_words_dec (
  sel,
  words
);
`include "adcb_regs.vh"
  input  wire [`ADCB_BUFLEN_W-1:0] sel;
  output wire [`ADCB_WORDS_W-1:0]  words;

  assign words = `ADCB_WORDS_ONE << sel; // RULE2
endmodule

// *** logic/adcb_pin_mode.v ***
`timescale 1ns/1ps
// Per-pin mode steering for one analog input
module adcb_pin_mode (
  digital_sel,
  present,
  module_disabled,
  digital_mode,
  port_read_en,
  mux_to_analog_ground
);
  input  wire digital_sel;
  input  wire present;
  input  wire module_disabled;
  output wire digital_mode;
  output wire port_read_en;
  output wire mux_to_analog_ground;

  wire dig;

  // Absent pins default to digital; disable forces digital
  assign dig = module_disabled | ~present | digital_sel; // RULE3 RULE4 RULE6 RULE8
  assign digital_mode         = dig;
  assign port_read_en         = dig; // RULE3
  assign mux_to_analog_ground = dig; // RULE3
endmodule

// *** logic/adcb_cfg.v ***
`timescale 1ns/1ps
// Functional notes
// RULE1 - Bits 15..3 of buffer-length register read zero, writes ignored.
// RULE2 - Three-bit field reserves two to the power value words per input.
// RULE3 - Config bit one: digital mode, port read on, mux to analog ground.
// RULE4 - Config bit zero: analog mode, port read off, pin sampled.
// RULE5 - High register bit n controls analog input n plus 16.
// RULE6 - All config bits read/write; bits without input have no effect.
// RULE7 - Second converter instance has no high pin configuration register.
// RULE8 - Module disabled: config ignored, all shared pins forced digital.
// RULE9 - Reset clears buffer-length field and all high config bits.
module adcb_cfg #(
  parameter HAS_PIN_HIGH = 1,
  parameter [15:0] PIN_PRESENT = 16'hFFFF
) (
  core_clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  converter_module_disable,
  buffer_words_per_input_sel,
  buffer_words_per_input,
  pin_digital_mode,
  pin_port_read_en,
  pin_mux_to_analog_ground
);
`include "adcb_regs.vh"
  input  wire                       core_clk;
  input  wire                       rst;
  input  wire [`ADCB_ADDR_W-1:0]    reg_addr;
  input  wire [`ADCB_DATA_W-1:0]    reg_wdata;
  input  wire                       reg_wr;
  input  wire                       reg_rd;
  output reg  [`ADCB_DATA_W-1:0]    reg_rdata;
  input  wire                       converter_module_disable;
  output wire [`ADCB_BUFLEN_W-1:0]  buffer_words_per_input_sel;
  output wire [`ADCB_WORDS_W-1:0]   buffer_words_per_input;
  output wire [`ADCB_DATA_W-1:0]    pin_digital_mode;
  output wire [`ADCB_DATA_W-1:0]    pin_port_read_en;
  output wire [`ADCB_DATA_W-1:0]    pin_mux_to_analog_ground;

  reg  [`ADCB_BUFLEN_W-1:0] buflen_ff;
  reg  [`ADCB_DATA_W-1:0]   pin_digital_select_high_ff;
  reg                       dis_meta_ff;
  reg                       dis_sync_ff;
  reg  [`ADCB_DATA_W-1:0]   nxt_rdata;
  wire [`ADCB_DATA_W-1:0]   present_vec;

  // Disable bit may come from another domain
  always @(posedge core_clk) begin
    if (rst) begin
      dis_meta_ff <= 1'b0;
      dis_sync_ff <= 1'b0;
    end else begin
      dis_meta_ff <= converter_module_disable;
      dis_sync_ff <= dis_meta_ff;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      buflen_ff                  <= `ADCB_BUFLEN_RST; // RULE9
      pin_digital_select_high_ff <= `ADCB_PINHI_RST;  // RULE9
    end else if (reg_wr) begin
      if (reg_addr == `ADCB_IDX_BUFLEN)
        buflen_ff <= reg_wdata[`ADCB_BUFLEN_MSB:`ADCB_BUFLEN_LSB]; // RULE1
      if (reg_addr == `ADCB_IDX_PINHI && HAS_PIN_HIGH != 0)
        pin_digital_select_high_ff <= reg_wdata; // RULE6 RULE7
    end
  end

  always @* begin
    nxt_rdata = `ADCB_ZERO16;
    if (reg_rd) begin
      case (reg_addr)
        `ADCB_IDX_BUFLEN: nxt_rdata = {`ADCB_BUFLEN_PAD, buflen_ff}; // RULE1
        `ADCB_IDX_PINHI:
          if (HAS_PIN_HIGH != 0)
            nxt_rdata = pin_digital_select_high_ff; // RULE6 RULE7
        `ADCB_IDX_STATUS: nxt_rdata = {`ADCB_STATUS_PAD, dis_sync_ff};
        default:          nxt_rdata = `ADCB_ZERO16;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst)
      reg_rdata <= `ADCB_ZERO16;
    else
      reg_rdata <= nxt_rdata;
  end

  assign buffer_words_per_input_sel = buflen_ff;
  assign present_vec = PIN_PRESENT;

  adcb_words_dec u_words (
    .sel   (buflen_ff),
    .words (buffer_words_per_input)
  ); // RULE2

  genvar gi;
  generate
    for (gi = 0; gi < `ADCB_DATA_W; gi = gi + 1) begin : g_pin
      // Bit gi steers analog input gi+16
      adcb_pin_mode u_pin (
        .digital_sel          (pin_digital_select_high_ff[gi]), // RULE5
        .present              (present_vec[gi] & (HAS_PIN_HIGH != 0)),
        .module_disabled      (dis_sync_ff), // RULE8
        .digital_mode         (pin_digital_mode[gi]),
        .port_read_en         (pin_port_read_en[gi]),
        .mux_to_analog_ground (pin_mux_to_analog_ground[gi])
      );
    end
  endgenerate
endmodule

// *** verif/adcb_cfg_assertions.sv ***
`timescale 1ns/1ps
module adcb_chk(input wire core_clk,rst,reg_wr,reg_rd,converter_module_disable,
  input wire [3:0] reg_addr,input wire [2:0] buffer_words_per_input_sel,
  input wire [7:0] buffer_words_per_input,input wire [15:0] reg_wdata,reg_rdata,
  pin_digital_mode,pin_port_read_en,pin_mux_to_analog_ground);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_words_pow: assert property (buffer_words_per_input==8'h1<<buffer_words_per_input_sel)
    else $error("words");
  chk_read_en: assert property (pin_port_read_en==pin_digital_mode) else $error("rden");
  chk_mux_gnd: assert property (pin_mux_to_analog_ground==pin_digital_mode)
    else $error("mux");
  chk_buf_read: assert property (reg_rd&&reg_addr==4'h0|=>
    reg_rdata=={13'h0,$past(buffer_words_per_input_sel)}) else $error("rdata");
  chk_buf_write: assert property (reg_wr&&reg_addr==4'h0|=>
    buffer_words_per_input_sel==$past(reg_wdata[2:0])) else $error("sel");
  chk_pin_write: assert property ((!converter_module_disable)[*3]##0
    (reg_wr&&reg_addr==4'h1)|=>pin_digital_mode==$past(reg_wdata)) else $error("pin");
  chk_disable_all: assert property (converter_module_disable[*3]|->
    pin_digital_mode==16'hFFFF) else $error("forced");
  chk_reset_clear: assert property ($past(rst)&&!converter_module_disable|->
    buffer_words_per_input_sel==3'h0&&pin_digital_mode==16'h0000) else $error("reset");
endmodule
bind adcb_cfg adcb_chk u_adcb_chk(.*);

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk=0,rst=1,wr=0,rd=0,dis=0,rv=0;
  logic [3:0] a=0;
  logic [15:0] d=0,q,dm,pr,pm,eq[$];
  logic [7:0] w;
  logic [31:0] x=32'h7C9F1698;
  int miscompares=0,comparisons=0;
  adcb_cfg u_adcb_cfg(.core_clk(clk),.rst(rst),.reg_addr(a),.reg_wdata(d),.reg_wr(wr),.reg_rd(rd),
    .reg_rdata(q),.converter_module_disable(dis),.buffer_words_per_input_sel(),
    .buffer_words_per_input(w),.pin_digital_mode(dm),.pin_port_read_en(pr),
    .pin_mux_to_analog_ground(pm));
  initial forever #2 clk=~clk;
  function automatic [31:0] xs(input [31:0] v);
    v^=v<<13;
    v^=v>>17;
    return v^(v<<5);
  endfunction
  task automatic chk(string n,logic [15:0] v,e);
    comparisons++;
    if(v!==e) miscompares++;
    if(v!==e) $display("mismatch %s exp %h seen %h",n,e,v);
  endtask
  // One bus cycle; reads note the expected data
  task acc(logic r,logic [3:0] ad,logic [15:0] v);
    @(posedge clk);
    {a,d,wr,rd}<={ad,v,!r,r};
    if(r) eq.push_back(v);
    @(posedge clk);
    {wr,rd}<=2'b0;
  endtask
  always @(posedge clk) begin
    rv<=rd;
    if(rv) chk("rdata",q,eq.pop_front());
  end
  task conclude;
    if(eq.size()!=0) miscompares++;
    $display("comparisons %0d miscompares %0d",comparisons,miscompares);
    if(miscompares==0&&comparisons>0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat(10) @(posedge clk);
    rst<=0;
    acc(1,0,0);
    acc(1,1,0);
    // Codes 0..7 on buffer length, then random pin patterns
    for(int c=0;c<12;c++) begin
      x=xs(x);
      acc(0,c[3],c<8?{x[15:3],c[2:0]}:x[15:0]);
      acc(1,c[3],c<8?{13'h0,c[2:0]}:x[15:0]);
      if(c<8) chk("words",w,16'h1<<c);
      else chk("mode",dm,x[15:0]);
    end
    $display("register test done");
    dis<=1;
    repeat(4) @(posedge clk);
    chk("forced",dm,16'hFFFF);
    chk("rden",pr,16'hFFFF);
    chk("mux",pm,16'hFFFF);
    acc(1,2,1);
    acc(1,4'hF,0);
    repeat(2) @(posedge clk);
    dis<=0;
    repeat(4) @(posedge clk);
    chk("mode",dm,x[15:0]);
    chk("rden",pr,x[15:0]);
    chk("mux",pm,x[15:0]);
    $display("disable test done");
    rst<=1;
    repeat(2) @(posedge clk);
    rst<=0;
    acc(1,0,0);
    acc(1,1,0);
    chk("mode",dm,16'h0000);
    chk("words",w,16'h0001);
    repeat(2) @(posedge clk);
    $display("reset test done");
    conclude;
  end
endmodule
